// file: rtl/pcl_buf2.sv
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module pcl_buf2 #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [W-1:0] spare_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != 2'h2);
  assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  initial begin
    if (W < 1) $error("pcl_buf2: W must be at least 1");
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
      out_valid <= 1'b0;
      out_data <= '0;
      spare_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      out_valid <= (cnt_nxt != 2'h0);
      if (pop) begin
        out_data <= (cnt_r == 2'h2) ? spare_r : in_data;
      end else if (push && cnt_r == 2'h0) begin
        out_data <= in_data;
      end
      if (push && !pop && cnt_r == 2'h1) begin
        spare_r <= in_data;
      end
    end
  end
endmodule

// file: rtl/pcl_dev.sv
// Device end: request handling, word loading and initialization sequencing
//
// Operation
// - Request low clears load-complete within 600 ns
// - Request low pulls status low within 600 ns
// - Host holds request low at least 2 us
// - Status low pulse lasts 268 to 1506 us
// - Status released within 1506 us of request high
// - Unmonitoring host waits 1506 us before clocking
// - Monitoring host waits 2 us after status
// - Data word sampled on load clock rising edge
// - One word per clock, clock rate limited
// - Compression or security changes clocks per word
// - Internal oscillator: user mode 175-437 us later
// - User clock starts four load periods after
// - User clock option: delay plus 8576 edges
`timescale 1ns/1ps
`include "pcl_defines.svh"
module pcl_dev #(
  parameter int STATUS_MIN_CYC = `PCL_STATUS_MIN_CYC,
  parameter int INIT_MIN_CYC = `PCL_CD2UM_MIN_CYC,
  parameter int UINIT_EDGES = `PCL_UINIT_EDGES,
  parameter int STREAM_WORDS = `PCL_STREAM_WORDS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to the host
  pcl_if.dev lnk,
  // Load options
  input wire pcl_pkg::pcl_width_t width_sel,
  input wire logic [5:0] cyc_per_word,
  input wire logic init_src_user,
  // Loaded word stream
  output logic word_valid,
  input wire logic word_ready,
  output logic [31:0] word_data,
  // Status
  output logic user_mode,
  output logic overrun,
  output logic [15:0] words_loaded
);
  import pcl_pkg::*;

  logic [35:0] sync1_r;
  logic [35:0] sync2_r;
  logic lclk_d_r;
  logic uclk_d_r;
  pcl_dev_st_t st_r;
  logic [31:0] cnt_r;
  logic [5:0] cyc_r;
  logic in_valid_r;
  logic [31:0] in_data_r;
  logic buf_ready;
  logic done_r;
  logic status_low_r;

  wire req_n_s = sync2_r[35];
  wire lclk_s = sync2_r[34];
  wire status_s = sync2_r[33];
  wire uclk_s = sync2_r[32];
  wire [31:0] data_s = sync2_r[31:0];
  wire lclk_rise = lclk_s && !lclk_d_r;
  wire uclk_rise = uclk_s && !uclk_d_r;
  wire [5:0] cpw = (cyc_per_word == 6'h00) ? 6'h01 : cyc_per_word;
  wire last_cyc = (cyc_r == cpw - 6'h01);
  wire [31:0] word_mask = (width_sel == PCL_W8) ? 32'h0000_00FF :
                          (width_sel == PCL_W16) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  wire last_word = (words_loaded == 16'(STREAM_WORDS - 1));
  wire status_min_met = (cnt_r >= 32'(STATUS_MIN_CYC - 1));
  wire uinit_delay_met = (cnt_r >= 32'(`PCL_CD2CU_CYC));
  wire uinit_done = (cyc_r == 6'h00) && (cnt_r >= 32'(`PCL_CD2CU_CYC + UINIT_EDGES));
  wire osc_done = (cnt_r >= 32'(INIT_MIN_CYC - 1));

  initial begin
    if (STREAM_WORDS < 1 || STREAM_WORDS > 65535) $error("pcl_dev: STREAM_WORDS out of range");
    if (STATUS_MIN_CYC < 1 || INIT_MIN_CYC < 1) $error("pcl_dev: counts must be positive");
  end

  // Pins are asynchronous to pclk; data is held a full load-clock period so it settles with the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Request bit starts at its idle high level
      sync1_r <= 36'h8_0000_0000;
      sync2_r <= 36'h8_0000_0000;
      lclk_d_r <= 1'b0;
      uclk_d_r <= 1'b0;
    end else begin
      sync1_r <= {lnk.cfg_req_n, lnk.load_clock, lnk.status, lnk.user_init_clock, lnk.data};
      sync2_r <= sync1_r;
      lclk_d_r <= lclk_s;
      uclk_d_r <= uclk_s;
    end
  end

  // Two synchroniser stages plus one state flop keep the clearing well inside the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= DS_CLEAR;
      cnt_r <= 32'h0000_0000;
      cyc_r <= 6'h00;
      done_r <= 1'b0;
      status_low_r <= 1'b1;
      user_mode <= 1'b0;
      overrun <= 1'b0;
      words_loaded <= 16'h0000;
      in_valid_r <= 1'b0;
      in_data_r <= 32'h0000_0000;
    end else begin
      in_valid_r <= 1'b0;
      if (!req_n_s && st_r != DS_CLEAR) begin
        st_r <= DS_CLEAR;
        done_r <= 1'b0;
        status_low_r <= 1'b1;
        user_mode <= 1'b0;
        cnt_r <= 32'h0000_0000;
      end else begin
        case (st_r)
          DS_CLEAR: begin
            status_low_r <= 1'b1;
            done_r <= 1'b0;
            user_mode <= 1'b0;
            overrun <= 1'b0;
            words_loaded <= 16'h0000;
            cyc_r <= 6'h00;
            if (!req_n_s && cnt_r != 32'h0000_0000) begin
              cnt_r <= 32'h0000_0001;
            end else if (req_n_s && status_min_met) begin
              status_low_r <= 1'b0;
              st_r <= DS_WAIT;
            end else begin
              cnt_r <= cnt_r + 32'h0000_0001;
            end
          end
          DS_WAIT: begin
            // An outside agent may still hold status low; loading waits for the line
            if (status_s) begin
              st_r <= DS_LOAD;
            end
          end
          DS_LOAD: begin
            if (lclk_rise) begin
              if (last_cyc) begin
                cyc_r <= 6'h00;
                in_valid_r <= 1'b1;
                in_data_r <= data_s & word_mask;
                if (!buf_ready) begin
                  overrun <= 1'b1;
                end
                words_loaded <= words_loaded + 16'h0001;
                if (last_word) begin
                  done_r <= 1'b1;
                  cnt_r <= 32'h0000_0000;
                  st_r <= DS_INIT;
                end
              end else begin
                cyc_r <= cyc_r + 6'h01;
              end
            end
          end
          DS_INIT: begin
            if (init_src_user) begin
              // Edges before the enable delay are ignored
              if (!uinit_delay_met) begin
                cnt_r <= cnt_r + 32'h0000_0001;
              end else if (uclk_rise) begin
                cnt_r <= cnt_r + 32'h0000_0001;
              end
              if (uinit_done) begin
                st_r <= DS_USER;
                user_mode <= 1'b1;
              end
            end else begin
              cnt_r <= cnt_r + 32'h0000_0001;
              if (osc_done) begin
                st_r <= DS_USER;
                user_mode <= 1'b1;
              end
            end
          end
          DS_USER: begin
            user_mode <= 1'b1;
          end
          default: begin
            st_r <= DS_CLEAR;
          end
        endcase
      end
    end
  end

  // A word pushed into a full buffer is dropped and flagged; the link cannot be stalled
  pcl_buf2 #(.W(32)) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(in_valid_r),
    .in_ready(buf_ready),
    .in_data(in_data_r),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );

  assign lnk.load_complete = done_r;
  assign lnk.status_dev_o = 1'b0;
  assign lnk.status_dev_oe = status_low_r;
endmodule

// file: rtl/pcl_host.sv
// Host end: APB-controlled configuration request and word streaming
`timescale 1ns/1ps
`include "pcl_defines.svh"
module pcl_host #(
  parameter int CF2CK_CYC = `PCL_CF2CK_CYC,
  parameter int LCLK_HALF = `PCL_LCLK_HALF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the device
  pcl_if.host lnk
);
  import pcl_pkg::*;

  logic [1:0] lc_sync_r;
  logic [1:0] st_sync_r;
  pcl_host_st_t st_r;
  logic [31:0] cnt_r;
  logic [31:0] ctrl_r;
  logic req_n_r;
  logic lclk_r;
  logic uclk_r;
  logic [31:0] data_r;
  logic loaded_r;
  logic [5:0] edge_r;
  logic [15:0] div_r;
  logic fifo_valid;
  logic fifo_ready;
  logic [31:0] fifo_data;

  wire access = psel && penable && !pready;
  wire sel_ctrl = (paddr == `PCL_REG_CTRL);
  wire sel_stat = (paddr == `PCL_REG_STAT);
  wire sel_data = (paddr == `PCL_REG_DATA);
  // Writes land at the edge where pready is seen high, never earlier
  wire commit = psel && penable && pready && pwrite;
  wire data_wr = access && pwrite && sel_data;
  wire push = commit && sel_data && fifo_ready;
  wire stall = data_wr && !fifo_ready;
  wire start = commit && sel_ctrl && pwdata[`PCL_CTRL_START];
  wire done_s = lc_sync_r[1];
  wire status_s = st_sync_r[1];
  wire [5:0] cpw_raw = ctrl_r[`PCL_CTRL_CPW_LO +: 6];
  wire [5:0] cpw = (cpw_raw == 6'h00) ? 6'h01 : cpw_raw;
  wire half_done = (div_r == 16'(LCLK_HALF - 1));
  wire pop = (st_r == HS_SEND) && !lclk_r && !loaded_r && fifo_valid;
  wire [31:0] stat_word = {16'h0000, 2'h0, edge_r, 3'h0, loaded_r, fifo_valid, status_s, done_s, st_r != HS_IDLE};

  initial begin
    if (LCLK_HALF < 1 || LCLK_HALF > 65535) $error("pcl_host: LCLK_HALF out of range");
    if (CF2CK_CYC < 1) $error("pcl_host: CF2CK_CYC must be positive");
  end

  // APB: one wait state; writes to the data word wait while the buffer is full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl_r <= `PCL_CTRL_RST;
    end else begin
      pready <= access && !stall;
      pslverr <= access && !stall && !(sel_ctrl || sel_stat || sel_data);
      if (access && !pwrite) begin
        prdata <= sel_ctrl ? ctrl_r : (sel_stat ? stat_word : 32'h0000_0000);
      end
      if (commit && sel_ctrl) begin
        ctrl_r <= pwdata & ~(32'h0000_0001 << `PCL_CTRL_START);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lc_sync_r <= 2'h0;
      st_sync_r <= 2'h0;
    end else begin
      lc_sync_r <= {lc_sync_r[0], lnk.load_complete};
      st_sync_r <= {st_sync_r[0], lnk.status};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= HS_IDLE;
      cnt_r <= 32'h0000_0000;
      req_n_r <= 1'b1;
      lclk_r <= 1'b0;
      uclk_r <= 1'b0;
      data_r <= 32'h0000_0000;
      loaded_r <= 1'b0;
      edge_r <= 6'h00;
      div_r <= 16'h0000;
    end else if (start) begin
      st_r <= HS_PULSE;
      cnt_r <= 32'h0000_0000;
      req_n_r <= 1'b0;
      lclk_r <= 1'b0;
      uclk_r <= 1'b0;
      loaded_r <= 1'b0;
      edge_r <= 6'h00;
      div_r <= 16'h0000;
    end else begin
      case (st_r)
        HS_IDLE: begin
          req_n_r <= 1'b1;
        end
        HS_PULSE: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r >= 32'(`PCL_CFG_CYC - 1)) begin
            req_n_r <= 1'b1;
            cnt_r <= 32'h0000_0000;
            st_r <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (ctrl_r[`PCL_CTRL_MON]) begin
            if (status_s && cnt_r > 32'h0000_0004) begin
              cnt_r <= 32'h0000_0000;
              st_r <= HS_GAP;
            end
          end else if (cnt_r >= 32'(CF2CK_CYC - 1)) begin
            st_r <= HS_SEND;
          end
        end
        HS_GAP: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r >= 32'(`PCL_ST2CK_CYC - 1)) begin
            st_r <= HS_SEND;
          end
        end
        HS_SEND: begin
          // The clock pauses low whenever software has not supplied the next word
          if (pop) begin
            data_r <= fifo_data;
            loaded_r <= 1'b1;
            div_r <= 16'h0000;
          end else if (done_s && !lclk_r) begin
            // A high phase in progress runs out first so the last clock keeps its width
            lclk_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
            st_r <= HS_DONE;
          end else if (loaded_r) begin
            div_r <= half_done ? 16'h0000 : div_r + 16'h0001;
            if (half_done) begin
              lclk_r <= !lclk_r;
              if (lclk_r) begin
                edge_r <= (edge_r == cpw - 6'h01) ? 6'h00 : edge_r + 6'h01;
                loaded_r <= (edge_r != cpw - 6'h01);
              end
            end
          end
        end
        HS_DONE: begin
          if (cnt_r < 32'(`PCL_CD2CU_CYC)) begin
            cnt_r <= cnt_r + 32'h0000_0001;
          end else if (ctrl_r[`PCL_CTRL_UCLK]) begin
            div_r <= half_done ? 16'h0000 : div_r + 16'h0001;
            if (half_done) begin
              uclk_r <= !uclk_r;
            end
          end
        end
        default: begin
          st_r <= HS_IDLE;
        end
      endcase
    end
  end

  pcl_buf2 #(.W(32)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(pwdata),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  assign lnk.cfg_req_n = req_n_r;
  assign lnk.load_clock = lclk_r;
  assign lnk.user_init_clock = uclk_r;
  assign lnk.data = data_r;
  assign lnk.status_host_o = 1'b0;
  assign lnk.status_host_oe = ctrl_r[`PCL_CTRL_HOLD];
endmodule

// file: shared/pcl_defines.svh
// Offsets, fields and timing counts of the configuration load sequencer
`ifndef PCL_DEFINES_SVH
`define PCL_DEFINES_SVH
`define PCL_PCLK_PS 8000
`define PCL_CF2CD_NS 600
`define PCL_CF2CD_CYC ((`PCL_CF2CD_NS * 1000) / `PCL_PCLK_PS)
`define PCL_CFG_US 2
`define PCL_CFG_CYC ((`PCL_CFG_US * 1000000 + `PCL_PCLK_PS - 1) / `PCL_PCLK_PS)
`define PCL_STATUS_MIN_US 268
`define PCL_STATUS_MIN_CYC ((`PCL_STATUS_MIN_US * 1000000 + `PCL_PCLK_PS - 1) / `PCL_PCLK_PS)
`define PCL_STATUS_MAX_US 1506
`define PCL_STATUS_MAX_CYC ((`PCL_STATUS_MAX_US * 1000000) / `PCL_PCLK_PS)
`define PCL_CF2CK_US 1506
`define PCL_CF2CK_CYC ((`PCL_CF2CK_US * 1000000 + `PCL_PCLK_PS - 1) / `PCL_PCLK_PS)
`define PCL_ST2CK_US 2
`define PCL_ST2CK_CYC ((`PCL_ST2CK_US * 1000000 + `PCL_PCLK_PS - 1) / `PCL_PCLK_PS)
`define PCL_CD2UM_MIN_US 175
`define PCL_CD2UM_MIN_CYC ((`PCL_CD2UM_MIN_US * 1000000 + `PCL_PCLK_PS - 1) / `PCL_PCLK_PS)
`define PCL_CD2UM_MAX_US 437
`define PCL_CD2UM_MAX_CYC ((`PCL_CD2UM_MAX_US * 1000000) / `PCL_PCLK_PS)
`define PCL_LCLK_MIN_PERIOD_PS 8000
`define PCL_CD2CU_CYC ((4 * `PCL_LCLK_MIN_PERIOD_PS + `PCL_PCLK_PS - 1) / `PCL_PCLK_PS)
`define PCL_UINIT_EDGES 8576
`define PCL_LCLK_HALF 10
`define PCL_STREAM_WORDS 16
`define PCL_REG_CTRL 8'h00
`define PCL_REG_STAT 8'h04
`define PCL_REG_DATA 8'h08
`define PCL_CTRL_START 0
`define PCL_CTRL_MON 1
`define PCL_CTRL_UCLK 2
`define PCL_CTRL_HOLD 3
`define PCL_CTRL_CPW_LO 8
`define PCL_CTRL_RST 32'h0000_0102
`endif

// file: shared/pcl_if.sv
// Pin-level link between configuration host and loaded device
`timescale 1ns/1ps
interface pcl_if;
  logic cfg_req_n;
  logic load_clock;
  logic [31:0] data;
  logic load_complete;
  logic user_init_clock;
  logic status_dev_o;
  logic status_dev_oe;
  logic status_host_o;
  logic status_host_oe;
  logic status;
  // Open-drain status line with pull-up
  assign status = !((status_dev_oe && !status_dev_o) || (status_host_oe && !status_host_o));
  modport dev (input cfg_req_n, load_clock, data, user_init_clock, status,
    output load_complete, status_dev_o, status_dev_oe);
  modport host (output cfg_req_n, load_clock, data, user_init_clock, status_host_o, status_host_oe,
    input load_complete, status);
endinterface

// file: shared/pcl_pkg.sv
// Types shared by both ends of the configuration load link
package pcl_pkg;
  // Four-state base so the type can ride on a wire port
  typedef enum logic [1:0] {PCL_W8, PCL_W16, PCL_W32} pcl_width_t;
  typedef enum {DS_CLEAR, DS_WAIT, DS_LOAD, DS_INIT, DS_USER} pcl_dev_st_t;
  typedef enum {HS_IDLE, HS_PULSE, HS_WAIT, HS_GAP, HS_SEND, HS_DONE} pcl_host_st_t;
endpackage

// file: sim/parallel_config_load_sequencer_test.sv
// Self-checking bench: host and device ends joined over the load link
`timescale 1ns/1ps
module parallel_config_load_sequencer_test;
  import pcl_pkg::*;
  localparam int NW = 4;
  localparam int SMIN = 40;
  localparam int CF2CK = 60;
  localparam int INIT = 30;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  pcl_width_t width_sel = PCL_W32;
  logic [5:0] cyc_per_word = 6'h01;
  logic init_src_user = 1'b0, word_ready = 1'b1;
  logic word_valid, user_mode, overrun;
  logic [31:0] word_data;
  logic [15:0] words_loaded;
  logic [31:0] lfsr = 32'h0000_202F;
  int fails = 0, comparisons = 0;
  logic [31:0] got[$];

  always #4 pclk = ~pclk;

  pcl_if pcl_if_inst ();
  pcl_host #(.CF2CK_CYC(CF2CK)) pcl_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(pcl_if_inst.host));
  pcl_dev #(.STATUS_MIN_CYC(SMIN), .INIT_MIN_CYC(INIT), .UINIT_EDGES(8), .STREAM_WORDS(NW)) pcl_dev_inst (
    .pclk(pclk), .presetn(presetn), .lnk(pcl_if_inst.dev), .width_sel(width_sel), .cyc_per_word(cyc_per_word),
    .init_src_user(init_src_user), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
    .user_mode(user_mode), .overrun(overrun), .words_loaded(words_loaded));
  pcl_props #(.STATUS_MIN_CYC(SMIN), .STREAM_WORDS(NW), .CF2CK_CYC(CF2CK)) pcl_props_inst (.pclk(pclk),
    .presetn(presetn), .cfg_req_n(pcl_if_inst.cfg_req_n), .load_clock(pcl_if_inst.load_clock),
    .data(pcl_if_inst.data), .load_complete(pcl_if_inst.load_complete),
    .user_init_clock(pcl_if_inst.user_init_clock), .status(pcl_if_inst.status),
    .status_dev_oe(pcl_if_inst.status_dev_oe));

  // Collect words the device hands out
  always @(posedge pclk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      got.push_back(word_data);
    end
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction

  function automatic logic [31:0] masked(input logic [31:0] w, input pcl_width_t ws);
    return ws == PCL_W8 ? {24'h00_0000, w[7:0]} : ws == PCL_W16 ? {16'h0000, w[15:0]} : w;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int n;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      fails++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // A full run needs well under 20000 cycles
  initial begin
    #400000;
    fails++;
    test_done();
  end

  initial begin
    logic [31:0] rd;
    logic [31:0] w[NW];
    logic err;
    int n;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(8'h00, 1'b0, 32'h0000_0000, rd, err);
    chk("ctrl reset", rd, 32'h0000_0102);
    apb(8'h0C, 1'b1, 32'hFFFF_FFFF, rd, err);
    chk("unmapped write err", {31'h0, err}, 32'h0000_0001);
    apb(8'h0C, 1'b0, 32'h0000_0000, rd, err);
    chk("unmapped read", rd, 32'h0000_0000);
    $display("test 0 done");
    // Widths, clocks per word, status watching, init source and stall all vary
    for (int c = 0; c < 3; c++) begin
      @(posedge pclk);
      width_sel <= c == 0 ? PCL_W32 : c == 1 ? PCL_W8 : PCL_W16;
      cyc_per_word <= 6'(c + 1);
      init_src_user <= c == 1;
      word_ready <= c != 1;
      got.delete();
      apb(8'h00, 1'b1, {18'h0_0000, 6'(c + 1), 5'h00, c == 1, c != 1, 1'b1}, rd, err);
      for (int i = 0; i < NW; i++) begin
        lfsr = next_rand(lfsr);
        w[i] = lfsr;
        apb(8'h08, 1'b1, w[i], rd, err);
      end
      n = 0;
      while (pcl_if_inst.load_complete !== 1'b1 && n < 5000) begin
        @(posedge pclk);
        n++;
      end
      chk("user mode early", {31'h0, user_mode}, 32'h0000_0000);
      n = 0;
      while (user_mode !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      chk("init delay", {31'h0, user_mode === 1'b1 && n >= (c == 1 ? 20 : INIT - 1)}, 32'h0000_0001);
      chk("words loaded", {16'h0000, words_loaded}, NW);
      chk("overrun", {31'h0, overrun}, {31'h0, c == 1});
      word_ready <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("stream count", 32'(got.size()), c == 1 ? 2 : NW);
      for (int i = 0; i < got.size(); i++) begin
        chk("word", got[i], masked(w[i], width_sel));
      end
      apb(8'h04, 1'b0, 32'h0000_0000, rd, err);
      chk("stat done", {30'h0, rd[2:1]}, 32'h0000_0003);
      $display("test %0d done", c + 1);
    end
    test_done();
  end
endmodule

// file: sim/pcl_props.sv
// Timing properties watched on the configuration load link
`timescale 1ns/1ps
module pcl_props #(
  parameter int STATUS_MIN_CYC = 40,
  parameter int STREAM_WORDS = 4,
  parameter int CF2CK_CYC = 60
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link pins
  input wire logic cfg_req_n,
  input wire logic load_clock,
  input wire logic [31:0] data,
  input wire logic load_complete,
  input wire logic user_init_clock,
  input wire logic status,
  input wire logic status_dev_oe
);
  // 600 ns, 2 us and the 1506 us ceiling, all at 8 ns a cycle
  localparam int REQ_CYC = 75;
  localparam int GAP_CYC = 250;
  localparam int MAX_CYC = 188250;
  logic [19:0] lo_cnt_r, dlo_cnt_r, rel_cnt_r, st_cnt_r, rq_cnt_r, rise_cnt_r;
  logic lclk_q_r;
  wire lclk_rise = load_clock && !lclk_q_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lo_cnt_r, dlo_cnt_r, rel_cnt_r, st_cnt_r, rq_cnt_r, rise_cnt_r, lclk_q_r} <= '0;
    end else begin
      lo_cnt_r <= cfg_req_n ? '0 : lo_cnt_r + 1'b1;
      dlo_cnt_r <= status_dev_oe ? dlo_cnt_r + 1'b1 : '0;
      rel_cnt_r <= (cfg_req_n && status_dev_oe) ? rel_cnt_r + 1'b1 : '0;
      st_cnt_r <= status ? st_cnt_r + 1'b1 : '0;
      rq_cnt_r <= cfg_req_n ? rq_cnt_r + 1'b1 : '0;
      rise_cnt_r <= !cfg_req_n ? '0 : rise_cnt_r + lclk_rise;
      lclk_q_r <= load_clock;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_req_fall;
    $fell(cfg_req_n);
  endsequence
  sequence s_first_rise;
    $rose(load_clock) ##0 (rise_cnt_r == '0);
  endsequence
  a_done_clears: assert property (s_req_fall |-> ##[0:REQ_CYC] !load_complete)
    else $error("load complete not cleared after request");
  a_status_pulled: assert property (s_req_fall |-> ##[0:REQ_CYC] (status_dev_oe && !status))
    else $error("status not pulled low after request");
  a_req_width: assert property ($rose(cfg_req_n) |-> lo_cnt_r >= GAP_CYC)
    else $error("request pulse too short");
  a_status_min: assert property ($fell(status_dev_oe) |-> dlo_cnt_r >= STATUS_MIN_CYC - 1)
    else $error("status low pulse too short");
  a_status_release: assert property (rel_cnt_r < MAX_CYC && dlo_cnt_r <= MAX_CYC)
    else $error("status held low too long");
  a_first_clock: assert property (s_first_rise |-> (st_cnt_r >= GAP_CYC || rq_cnt_r >= CF2CK_CYC - 1))
    else $error("load clock started too early");
  a_data_held: assert property ($rose(load_clock) |-> $stable(data) ##1 $stable(data) [*2])
    else $error("data moved at load clock rise");
  a_clock_half: assert property ($changed(load_clock) |=> $stable(load_clock) [*8])
    else $error("load clock phase too short");
  a_user_clk_gap: assert property ($rose(load_complete) |-> (!$rose(user_init_clock)) [*4])
    else $error("user clock started too soon");
  a_done_after_all: assert property ($rose(load_complete) |-> rise_cnt_r >= STREAM_WORDS)
    else $error("load complete before whole stream");
endmodule
